/* hw/nir_report.sv */
// Namespace identify report: size, capacity, utilization and feature byte
// Operation
// (R1) Bytes 7:0 give the namespace block total; addresses run 0 to total minus 1.
// (R2) Counts are in the formatted block size and mean nothing before a format.
// (R3) Bytes 15:8 give the block capacity, never above the block total.
// (R4) Capacity leaves out spare blocks held in reserve.
// (R5) Bytes 23:16 give blocks in use, never above capacity.
// (R6) A block becomes allocated when written or write-uncorrectable targeted.
// (R7) A deallocate command may return blocks to the unallocated state.
// (R8) Without thin provisioning the in-use value may simply equal capacity.
// (R9) Byte 24 is the feature byte with bits 7:3 reserved as zero.
// (R10) Feature bit 2 reports deallocated-or-unwritten error support.
// (R11) Feature bit 1 says the per-namespace atomic write units are valid.
// (R12) Feature bit 0 reports thin provisioning; deallocation lowers in-use.
// (R13) With feature bit 0 clear, total and capacity report the same value; the code reports capacity as total minus spare blocks.
// (R14) Block size follows bits 3:0 of the format select byte at offset 26.
// (R15) In-use moves only on real allocation changes; bytes go out low first.
module nir_report #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Namespace provisioning from controller firmware
   input  wire logic        cfg_thin_en,
   input  wire logic        cfg_dealloc_err_en,
   input  wire logic        cfg_ns_atomic_en,
   input  wire logic [63:0] cfg_raw_blocks,
   input  wire logic [63:0] cfg_spare_blocks,
   input  wire logic [63:0] cfg_thin_capacity,
   input  wire logic [63:0] fmt_block_count [nir_pkg::FMT_COUNT],
   // Format command
   input  wire logic        format_req,
   input  wire logic [3:0]  format_sel,
   // Block events from the I/O path
   input  wire logic        wr_valid,
   input  wire logic        wr_uncorr_valid,
   input  wire logic        dealloc_valid,
   input  wire logic [63:0] io_lba,
   // Identify read port
   input  wire logic        id_rd,
   input  wire logic [4:0]  id_addr,
   output logic [7:0]       id_rdata,
   output logic             id_rvalid,
   // Status
   output logic             ns_formatted
);
   nir_pkg::nir_state_t state_reg;
   nir_pkg::nir_state_t state_next;
   logic [63:0] total_reg;
   logic [63:0] total_next;
   logic [63:0] cap_reg;
   logic [63:0] cap_next;
   logic [63:0] use_reg;
   logic [63:0] use_next;
   logic [3:0]  fmt_reg;
   logic [3:0]  fmt_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [7:0]  feat_byte;
   logic [63:0] fmt_total;
   logic [63:0] avail;
   logic [63:0] cap_pick;
   logic        ev_valid;
   logic        ev_alloc;
   logic        map_clear;
   logic        inc_pulse;
   logic        dec_pulse;
   logic        in_range;

   // (R14) Block count for selected format
   assign fmt_total = fmt_block_count[fmt_reg];

   // (R9) Reserved bits read zero
   always_comb begin
      feat_byte = nir_pkg::RST_BYTE;
      // (R12) Thin provisioning flag
      feat_byte[nir_pkg::FEAT_THIN_BIT]    = cfg_thin_en;
      // (R11) Per-namespace atomic units valid
      feat_byte[nir_pkg::FEAT_NS_ATOM_BIT] = cfg_ns_atomic_en;
      // (R10) Unwritten-block error support
      feat_byte[nir_pkg::FEAT_DEALLOC_BIT] = cfg_dealloc_err_en;
   end

   // (R4) Spares never counted in capacity
   assign avail = (fmt_total > cfg_spare_blocks) ? (fmt_total - cfg_spare_blocks) : nir_pkg::RST_COUNT;

   always_comb begin
      // (R13) No thin provisioning: capacity equals total minus spares
      if (!cfg_thin_en) begin
         cap_pick = avail;
      // (R3) Capacity clamped to total minus spares
      end else if (cfg_thin_capacity < avail) begin
         cap_pick = cfg_thin_capacity;
      end else begin
         cap_pick = avail;
      end
   end

   // (R1) Addresses beyond total are not tracked
   assign in_range = (state_reg == nir_pkg::NIR_READY) && (io_lba < total_reg)
                     && (io_lba[63:ADDR_W] == '0);
   // (R6) Writes allocate
   // (R7) Deallocate releases only when thin provisioning is on
   assign ev_valid  = in_range && (wr_valid || wr_uncorr_valid || (dealloc_valid && cfg_thin_en));
   assign ev_alloc  = wr_valid || wr_uncorr_valid;
   assign map_clear = (state_reg == nir_pkg::NIR_FORMAT);

   nir_alloc_map #(
      .ADDR_W (ADDR_W)
   ) u_map (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .clear_all (map_clear),
      .ev_valid  (ev_valid),
      .ev_alloc  (ev_alloc),
      .ev_addr   (io_lba[ADDR_W-1:0]),
      .inc_pulse (inc_pulse),
      .dec_pulse (dec_pulse)
   );

   always_comb begin
      state_next = state_reg;
      total_next = total_reg;
      cap_next   = cap_reg;
      use_next   = use_reg;
      fmt_next   = fmt_reg;
      case (state_reg)
         nir_pkg::NIR_IDLE: begin
            if (format_req) begin
               // (R14) Latch format choice
               fmt_next   = format_sel;
               state_next = nir_pkg::NIR_FORMAT;
            end
         end
         nir_pkg::NIR_FORMAT: begin
            // (R2) Counts defined from here on
            total_next = fmt_total;
            cap_next   = cap_pick;
            use_next   = nir_pkg::RST_COUNT;
            state_next = nir_pkg::NIR_READY;
         end
         nir_pkg::NIR_READY: begin
            if (format_req) begin
               fmt_next   = format_sel;
               state_next = nir_pkg::NIR_FORMAT;
            end else if (inc_pulse && use_reg < cap_reg) begin
               // (R5) Never above capacity
               use_next = use_reg + 64'h1;
            end else if (dec_pulse && use_reg != nir_pkg::RST_COUNT) begin
               // (R12) Deallocation lowers in-use
               use_next = use_reg - 64'h1;
            end
         end
         default: begin
            state_next = nir_pkg::NIR_IDLE;
         end
      endcase
   end

   // (R15) Little-endian byte read
   always_comb begin
      rvalid_next = id_rd;
      rdata_next  = nir_pkg::RST_BYTE;
      if (!id_rd) begin
         rdata_next = nir_pkg::RST_BYTE;
      end else if (id_addr < nir_pkg::OFS_BLOCK_CAPACITY) begin
         // (R1) Block total field
         rdata_next = total_reg[8*id_addr[2:0] +: 8];
      end else if (id_addr < nir_pkg::OFS_BLOCKS_IN_USE) begin
         // (R3) Capacity field
         rdata_next = cap_reg[8*id_addr[2:0] +: 8];
      end else if (id_addr < nir_pkg::OFS_FEATURE_FLAGS) begin
         // (R8) Fixed-allocation parts report capacity
         rdata_next = cfg_thin_en ? use_reg[8*id_addr[2:0] +: 8] : cap_reg[8*id_addr[2:0] +: 8];
      end else if (id_addr == nir_pkg::OFS_REPORT_LAST) begin
         rdata_next = feat_byte;
      end else if (id_addr == nir_pkg::OFS_FORMAT_SELECT) begin
         rdata_next = {4'h0, fmt_reg};
      end else begin
         rdata_next = nir_pkg::RST_BYTE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg  <= nir_pkg::NIR_IDLE;
         total_reg  <= nir_pkg::RST_COUNT;
         cap_reg    <= nir_pkg::RST_COUNT;
         use_reg    <= nir_pkg::RST_COUNT;
         fmt_reg    <= nir_pkg::RST_FMT_SEL;
         rdata_reg  <= nir_pkg::RST_BYTE;
         rvalid_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         total_reg  <= total_next;
         cap_reg    <= cap_next;
         use_reg    <= use_next;
         fmt_reg    <= fmt_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign id_rdata     = rdata_reg;
   assign id_rvalid    = rvalid_reg;
   assign ns_formatted = (state_reg == nir_pkg::NIR_READY);
endmodule // nir_report

/* hw/nir_pkg.sv */
// Package with offsets, field positions and reset values of the namespace identify report
package nir_pkg;
   // Byte offsets of the report fields
   localparam logic [4:0] OFS_BLOCK_TOTAL    = 5'h00;
   localparam logic [4:0] OFS_BLOCK_CAPACITY = 5'h08;
   localparam logic [4:0] OFS_BLOCKS_IN_USE  = 5'h10;
   localparam logic [4:0] OFS_FEATURE_FLAGS  = 5'h18;
   localparam logic [4:0] OFS_REPORT_LAST    = 5'h18;
   localparam logic [4:0] OFS_FORMAT_SELECT  = 5'h1A;
   // Feature byte bit positions
   localparam int FEAT_THIN_BIT    = 0;
   localparam int FEAT_NS_ATOM_BIT = 1;
   localparam int FEAT_DEALLOC_BIT = 2;
   // Formatted size selector field
   localparam int FMT_SEL_W = 4;
   localparam int FMT_COUNT = 16;
   // Reset values
   localparam logic [63:0] RST_COUNT   = 64'h0000_0000_0000_0000;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [3:0]  RST_FMT_SEL = 4'h0;
   // Command states
   typedef enum logic [1:0] {
      NIR_IDLE   = 2'b00,
      NIR_FORMAT = 2'b01,
      NIR_READY  = 2'b10
   } nir_state_t;
endpackage

/* hw/nir_alloc_map.sv */
// Per-block allocation bitmap with in-use change reporting
module nir_alloc_map #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Clear all on format
   input  wire logic              clear_all,
   // Block event
   input  wire logic              ev_valid,
   input  wire logic              ev_alloc,
   input  wire logic [ADDR_W-1:0] ev_addr,
   // Resulting count change
   output logic                   inc_pulse,
   output logic                   dec_pulse
);
   localparam int DEPTH = 1 << ADDR_W;

   logic [DEPTH-1:0] map_reg;
   logic [DEPTH-1:0] map_next;
   logic             inc_reg;
   logic             inc_next;
   logic             dec_reg;
   logic             dec_next;

   always_comb begin
      map_next = map_reg;
      inc_next = 1'b0;
      dec_next = 1'b0;
      if (clear_all) begin
         map_next = '0;
      end else if (ev_valid) begin
         // (R15) Count only real transitions
         if (ev_alloc && !map_reg[ev_addr]) begin
            inc_next = 1'b1;
         end else if (!ev_alloc && map_reg[ev_addr]) begin
            dec_next = 1'b1;
         end
         map_next[ev_addr] = ev_alloc;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         map_reg <= '0;
         inc_reg <= 1'b0;
         dec_reg <= 1'b0;
      end else begin
         map_reg <= map_next;
         inc_reg <= inc_next;
         dec_reg <= dec_next;
      end
   end

   assign inc_pulse = inc_reg;
   assign dec_pulse = dec_reg;
endmodule // nir_alloc_map

/* sim/nir_report_monitor.sv */
// Assertion checker on the identify report ports
module nir_mon #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   // Controls
   input wire logic       cfg_thin_en,
   input wire logic       cfg_dealloc_err_en,
   input wire logic       cfg_ns_atomic_en,
   input wire logic       format_req,
   input wire logic [3:0] format_sel,
   input wire logic       id_rd,
   input wire logic [4:0] id_addr,
   // Answers
   input wire logic [7:0] id_rdata,
   input wire logic       id_rvalid,
   input wire logic       ns_formatted
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] sel_reg;
   logic [3:0] sel_next;
   logic       rd_feat;
   assign rd_feat = id_rd && id_addr == 5'h18;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   always_comb sel_next = format_req ? format_sel : sel_reg;
   always_ff @(posedge ref_clk) sel_reg <= sel_next;
   a_rvalid_after_rd: assert property (id_rd |=> id_rvalid)
      else $error("no valid after read");
   a_rvalid_only_rd: assert property (!id_rd |=> !id_rvalid)
      else $error("valid without read");
   a_feat_reserved: assert property (rd_feat |=> id_rdata[7:3] == 5'h00)
      else $error("reserved feature bits set");
   a_feat_flags: assert property (rd_feat && ns_formatted |=>
      id_rdata[2:0] == {cfg_dealloc_err_en, cfg_ns_atomic_en, cfg_thin_en})
      else $error("feature flags wrong");
   a_fmt_sel_byte: assert property (id_rd && id_addr == 5'h1A && ns_formatted |=>
      id_rdata == {4'h0, sel_reg})
      else $error("format select byte wrong");
   a_spare_zero: assert property (id_rd && id_addr > 5'h18 && id_addr != 5'h1A |=> id_rdata == 8'h00)
      else $error("unused byte not zero");
   a_format_two: assert property (format_req |=> !ns_formatted ##1 ns_formatted)
      else $error("format timing wrong");
   a_stays_ready: assert property (ns_formatted && !format_req |=> ns_formatted)
      else $error("formatted state lost");
   a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !ns_formatted && !id_rvalid)
      else $error("reset did not clear");
   c_format: cover property (format_req ##2 ns_formatted);
   c_thin_use: cover property (id_rd && id_addr == 5'h10 && cfg_thin_en);
   c_feat_thin: cover property (id_rvalid && id_rdata[0]);
endmodule // nir_mon

bind nir_report nir_mon #(.ADDR_W(ADDR_W)) u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .cfg_thin_en(cfg_thin_en), .cfg_dealloc_err_en(cfg_dealloc_err_en), .cfg_ns_atomic_en(cfg_ns_atomic_en),
   .format_req(format_req), .format_sel(format_sel), .id_rd(id_rd), .id_addr(id_addr),
   .id_rdata(id_rdata), .id_rvalid(id_rvalid), .ns_formatted(ns_formatted));

/* sim/nir_host_model.sv */
// Host model issuing format, block and identify requests
module nir_host (
   // Clock
   input  wire logic   ref_clk,
   // Requests
   output logic        format_req,
   output logic [3:0]  format_sel,
   output logic        wr_valid,
   output logic        wr_uncorr_valid,
   output logic        dealloc_valid,
   output logic [63:0] io_lba,
   output logic        id_rd,
   output logic [4:0]  id_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {format_req, format_sel, wr_valid, wr_uncorr_valid, dealloc_valid, io_lba, id_rd, id_addr} = '0;
   // Back to back byte reads; address scrambled once released
   task automatic rd(input logic [4:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         id_rd = 1'b1;
         id_addr = a + 5'(i);
      end
      @(negedge ref_clk);
      id_rd = 1'b0;
      id_addr = ~id_addr;
   endtask
   task automatic ev(input logic [2:0] kind, input logic [63:0] lba);
      @(negedge ref_clk);
      {dealloc_valid, wr_uncorr_valid, wr_valid} = kind;
      io_lba = lba;
      @(negedge ref_clk);
      {dealloc_valid, wr_uncorr_valid, wr_valid} = 3'h0;
      io_lba = ~lba;
   endtask
   task automatic fmt(input logic [3:0] sel);
      @(negedge ref_clk);
      format_req = 1'b1;
      format_sel = sel;
      @(negedge ref_clk);
      format_req = 1'b0;
      format_sel = ~sel;
      repeat (2) @(negedge ref_clk);
   endtask
endmodule // nir_host

/* sim/nir_report_tb_top.sv */
// Self-checking bench for the namespace identify report
module nir_report_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        thin, derr, atom, format_req, wr_valid, wr_uncorr_valid, dealloc_valid, id_rd, id_rvalid, ns_fmt;
   logic [3:0]  format_sel;
   logic [4:0]  id_addr;
   logic [7:0]  id_rdata;
   logic [63:0] spare, tcap, io_lba;
   logic [63:0] fbc [nir_pkg::FMT_COUNT];
   logic [7:0]  exp_q [$];
   bit          used [32];
   int          bad_count = 0;
   int          comparisons = 0;
   int          seed = 50969;
   always #4 ref_clk = ~ref_clk;
   nir_host u_host (.ref_clk(ref_clk), .format_req(format_req), .format_sel(format_sel), .wr_valid(wr_valid),
      .wr_uncorr_valid(wr_uncorr_valid), .dealloc_valid(dealloc_valid), .io_lba(io_lba), .id_rd(id_rd),
      .id_addr(id_addr));
   nir_report DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_thin_en(thin), .cfg_dealloc_err_en(derr),
      .cfg_ns_atomic_en(atom), .cfg_raw_blocks(64'h0), .cfg_spare_blocks(spare), .cfg_thin_capacity(tcap),
      .fmt_block_count(fbc), .format_req(format_req), .format_sel(format_sel), .wr_valid(wr_valid),
      .wr_uncorr_valid(wr_uncorr_valid), .dealloc_valid(dealloc_valid), .io_lba(io_lba), .id_rd(id_rd),
      .id_addr(id_addr), .id_rdata(id_rdata), .id_rvalid(id_rvalid), .ns_formatted(ns_fmt));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("Error id_rdata expected %h seen %h", want, seen);
      end
   endtask
   task automatic final_report();
      if (exp_q.size() != 0) bad_count++;
      if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic expect_field(input logic [4:0] a, input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) exp_q.push_back(v[8*i +: 8]);
      u_host.rd(a, n);
   endtask
   always @(negedge ref_clk)
      if (id_rvalid === 1'b1) check(id_rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
   initial begin
      logic [63:0] tot, cap, use_cnt;
      logic [3:0]  sel;
      logic [4:0]  lba;
      {thin, derr, atom, spare, tcap} = '0;
      for (int i = 0; i < 16; i++) fbc[i] = 64'(512 + ($random(seed) & 511));
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         {derr, atom, thin} = 3'(k);
         sel = 4'($random(seed));
         spare = thin ? 64'(k) : 64'h0;
         tcap = (k == 1) ? '1 : 64'(200 + ($random(seed) & 127));
         u_host.fmt(sel);
         tot = fbc[sel];
         cap = (thin && tcap < tot - spare) ? tcap : tot - spare;
         use_cnt = thin ? 64'h0 : cap;
         expect_field(5'h00, tot, 8);
         expect_field(5'h08, cap, 8);
         expect_field(5'h10, use_cnt, 8);
         expect_field(5'h18, 64'({derr, atom, thin}), 1);
         expect_field(5'h1A, 64'(sel), 2);
         used = '{default: 1'b0};
         for (int j = 0; j < 24; j++) begin
            lba = 5'($random(seed));
            u_host.ev(3'h1 << (j % 3), 64'(lba));
            if (thin && j % 3 == 2 && used[lba]) use_cnt--;
            if (thin && j % 3 != 2 && !used[lba]) use_cnt++;
            if (thin) used[lba] = (j % 3 != 2);
         end
         u_host.ev(3'h1, tot);
         repeat (2) @(negedge ref_clk);
         expect_field(5'h10, use_cnt, 8);
      end
      @(negedge ref_clk) sys_rst = 1'b1;
      @(negedge ref_clk) sys_rst = 1'b0;
      expect_field(5'h10, 64'h0, 8);
      repeat (4) @(negedge ref_clk);
      final_report();
   end
endmodule // nir_report_tb_top
